/* File: rtl/vdpm_regs.sv */
// Register area of the virtual memory, with host and web ports and firmware inputs.
// Ports are synchronous to clk_i; requests arrive already resynchronised.
`timescale 1ns/1ns
`default_nettype none
`include "vdpm_cfg.svh"
module vdpm_regs (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              late_level_i,
  input  wire vdpm_pkg::bus_req_t host_req_i,
  input  wire vdpm_pkg::bus_req_t web_req_i,
  input  wire vdpm_pkg::fw_evt_t  fw_i,
  input  wire logic              rx_dat_we_i,
  input  wire logic [`DAT_IDX_W-1:0] rx_dat_idx_i,
  input  wire logic [15:0]       rx_dat_i,
  output vdpm_pkg::bus_rsp_t     host_rsp_o,
  output vdpm_pkg::bus_rsp_t     web_rsp_o,
  output logic                   host_write_indication_flag_o
);
  logic [15:0] sync_q, cmdf_q, rxlen_q, rxtag_q, txlen_q, txtag_q;
  logic [31:0] rxcmd_q, rxerr_q, txcmd_q, txerr_q;
  logic [15:0] rxdat_q [`DAT_WORDS];
  logic [15:0] txdat_q [`DAT_WORDS];
  logic [15:0] user_q  [`USER_WORDS];
  logic        flag_q;
  logic        web_ok;
  logic        h_wr, h_rd, w_wr, w_rd, web_hi, host_hi;
  logic [`ADDR_W-1:0] h_rel_tx, h_rel_u, w_rel_u;

  assign web_hi = (web_req_i.addr >= `WEB_HI_MIN) && (web_req_i.addr <= `WEB_HI_MAX);
  assign web_ok = (web_req_i.addr <= `WEB_LO_MAX) || (web_hi && late_level_i);
  assign host_hi = host_req_i.addr >= `WEB_HI_MIN;
  assign h_wr = ce_i && host_req_i.req && host_req_i.we && (!host_hi || late_level_i);
  assign h_rd = ce_i && host_req_i.req && !host_req_i.we;
  assign w_wr = ce_i && web_req_i.req && web_req_i.we && web_ok;
  assign w_rd = ce_i && web_req_i.req && !web_req_i.we;
  assign h_rel_tx = host_req_i.addr - `TXDAT_BASE;
  assign h_rel_u  = host_req_i.addr - `USER_BASE;
  assign w_rel_u  = web_req_i.addr - `USER_BASE;

  // Read mux; also returns zero for unused or unreachable words.
  function automatic logic [15:0] rd_word(input logic [`ADDR_W-1:0] a, input logic ok);
    logic [`ADDR_W-1:0] ru, rr, rt;
    ru = a - `USER_BASE;
    rr = a - `RXDAT_BASE;
    rt = a - `TXDAT_BASE;
    rd_word = `ZERO16;
    if (ok) begin
      case (a)
        `SYNC_ADDR:        rd_word = sync_q;
        `CMDF_ADDR:        rd_word = cmdf_q;
        `RXCMD_ADDR:       rd_word = rxcmd_q[15:0];
        `RXCMD_ADDR + `HI_OFS: rd_word = rxcmd_q[31:16];
        `RXERR_ADDR:       rd_word = rxerr_q[15:0];
        `RXERR_ADDR + `HI_OFS: rd_word = rxerr_q[31:16];
        `RXLEN_ADDR:       rd_word = rxlen_q;
        `RXTAG_ADDR:       rd_word = rxtag_q;
        `TXCMD_ADDR:       rd_word = txcmd_q[15:0];
        `TXCMD_ADDR + `HI_OFS: rd_word = txcmd_q[31:16];
        `TXERR_ADDR:       rd_word = txerr_q[15:0];
        `TXERR_ADDR + `HI_OFS: rd_word = txerr_q[31:16];
        `TXLEN_ADDR:       rd_word = txlen_q;
        `TXTAG_ADDR:       rd_word = txtag_q;
        default: begin
          if (a >= `RXDAT_BASE && rr < `DAT_WORDS)
            rd_word = rxdat_q[rr[`DAT_IDX_W-1:0]];
          else if (a >= `TXDAT_BASE && rt < `DAT_WORDS)
            rd_word = txdat_q[rt[`DAT_IDX_W-1:0]];
          else if (a >= `USER_BASE && ru < `USER_WORDS)
            rd_word = user_q[ru[`USER_IDX_W-1:0]];
        end
      endcase
    end
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rsp_o <= '0;
      web_rsp_o  <= '0;
    end else if (ce_i) begin
      host_rsp_o.valid <= host_req_i.req;
      host_rsp_o.rdata <= h_rd ? rd_word(host_req_i.addr, !host_hi || late_level_i) : `ZERO16;
      web_rsp_o.valid  <= web_req_i.req;
      web_rsp_o.rdata  <= w_rd ? rd_word(web_req_i.addr, web_ok) : `ZERO16;
    end
  end

  // Sync word and its flag; a write in the same cycle as a read wins.
  logic sync_rd, sync_wr;
  assign sync_rd = (h_rd && host_req_i.addr == `SYNC_ADDR) ||
                   (w_rd && web_ok && web_req_i.addr == `SYNC_ADDR);
  assign sync_wr = (h_wr && host_req_i.addr == `SYNC_ADDR) ||
                   (w_wr && web_req_i.addr == `SYNC_ADDR);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
      sync_q <= `ZERO16;
      host_write_indication_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (sync_wr)
        flag_q <= 1'b1;
      else if (sync_rd)
        flag_q <= 1'b0;
      if (h_wr && host_req_i.addr == `SYNC_ADDR)
        sync_q <= host_req_i.wdata;
      else if (w_wr && web_req_i.addr == `SYNC_ADDR)
        sync_q <= web_req_i.wdata;
      host_write_indication_flag_o <= sync_wr ? 1'b1 : (sync_rd ? 1'b0 : flag_q);
    end
  end

  // Host-written control words.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmdf_q  <= `ZERO16;
      txcmd_q <= `ZERO32;
      txlen_q <= `ZERO16;
      txtag_q <= `ZERO16;
    end else if (h_wr) begin
      case (host_req_i.addr)
        `CMDF_ADDR:          cmdf_q <= host_req_i.wdata;
        `TXCMD_ADDR:         txcmd_q[15:0] <= host_req_i.wdata;
        `TXCMD_ADDR + `HI_OFS: txcmd_q[31:16] <= host_req_i.wdata;
        `TXLEN_ADDR:         txlen_q <= host_req_i.wdata;
        `TXTAG_ADDR:         txtag_q <= host_req_i.wdata;
        default:             txtag_q <= txtag_q;
      endcase
    end
  end

  // Firmware-side receive and error words.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxcmd_q <= `ZERO32;
      rxerr_q <= `ZERO32;
      rxlen_q <= `ZERO16;
      rxtag_q <= `ZERO16;
      txerr_q <= `ZERO32;
    end else if (ce_i) begin
      if (fw_i.rx_done) begin
        rxcmd_q <= fw_i.rx_cmd;
        rxlen_q <= fw_i.rx_len;
        rxtag_q <= fw_i.rx_tag;
      end
      if (fw_i.rx_done && fw_i.rx_err_v)
        rxerr_q <= fw_i.rx_err;
      if (fw_i.tx_err_v)
        txerr_q <= fw_i.tx_err;
    end
  end

  // Data areas, 16 entries each.
  genvar g;
  generate
    for (g = 0; g < `DAT_WORDS; g++) begin : g_dat
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rxdat_q[g] <= `ZERO16;
          txdat_q[g] <= `ZERO16;
        end else if (ce_i) begin
          if (rx_dat_we_i && rx_dat_idx_i == `DAT_IDX_W'(g))
            rxdat_q[g] <= rx_dat_i;
          if (h_wr && host_req_i.addr >= `TXDAT_BASE &&
              h_rel_tx == `ADDR_W'(g))
            txdat_q[g] <= host_req_i.wdata;
        end
      end
    end
    for (g = 0; g < `USER_WORDS; g++) begin : g_user
      always_ff @(posedge clk_i) begin
        if (rst_i)
          user_q[g] <= `ZERO16;
        else if (h_wr && host_req_i.addr >= `USER_BASE && h_rel_u == `ADDR_W'(g))
          user_q[g] <= host_req_i.wdata;
        else if (w_wr && web_req_i.addr >= `USER_BASE && w_rel_u == `ADDR_W'(g))
          user_q[g] <= web_req_i.wdata;
      end
    end
  endgenerate

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i) sync_wr |=> host_write_indication_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after sync write");

  property p_flag_clr;
    @(posedge clk_i) disable iff (rst_i)
      (sync_rd && !sync_wr) |=> !host_write_indication_flag_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared after read");

  property p_web_block;
    @(posedge clk_i) disable iff (rst_i)
      (w_rd && !web_ok) |=> web_rsp_o.rdata == `ZERO16;
  endproperty
  a_web_block: assert property (p_web_block) else $error("web read outside range");

  property p_late;
    @(posedge clk_i) disable iff (rst_i)
      (h_rd && host_hi && !late_level_i) |=> host_rsp_o.rdata == `ZERO16;
  endproperty
  a_late: assert property (p_late) else $error("late area visible early");

  property p_rxlen;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && fw_i.rx_done) |=> rxlen_q == $past(fw_i.rx_len);
  endproperty
  a_rxlen: assert property (p_rxlen) else $error("rx length not captured");

  property p_rxerr;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !fw_i.rx_done) |=> $stable(rxerr_q);
  endproperty
  a_rxerr: assert property (p_rxerr) else $error("rx error changed without message");

  property p_txerr;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && fw_i.tx_err_v) |=> txerr_q == $past(fw_i.tx_err);
  endproperty
  a_txerr: assert property (p_txerr) else $error("tx error not captured");

  property p_rsp;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && host_req_i.req) |=> host_rsp_o.valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("host request not answered");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!sync_wr && !sync_rd) |=> $stable(host_write_indication_flag_o);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved without sync access");

  property p_ce_freeze;
    @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(host_rsp_o) && $stable(web_rsp_o) &&
                $stable(host_write_indication_flag_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved while disabled");

  property p_web_rsp;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && web_req_i.req) |=> web_rsp_o.valid;
  endproperty
  a_web_rsp: assert property (p_web_rsp) else $error("web request not answered");

  property p_host_idle;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !host_req_i.req) |=> !host_rsp_o.valid;
  endproperty
  a_host_idle: assert property (p_host_idle) else $error("host answer without request");

  property p_host_wr_zero;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && host_req_i.req && host_req_i.we) |=> host_rsp_o.rdata == `ZERO16;
  endproperty
  a_host_wr_zero: assert property (p_host_wr_zero) else $error("write answer not zero");

  property p_txlen;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr == `TXLEN_ADDR) |=> txlen_q == $past(host_req_i.wdata);
  endproperty
  a_txlen: assert property (p_txlen) else $error("tx length not stored");

  property p_txtag;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr == `TXTAG_ADDR) |=> txtag_q == $past(host_req_i.wdata);
  endproperty
  a_txtag: assert property (p_txtag) else $error("tx tag not stored");

  property p_rxdat;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && rx_dat_we_i) |=> rxdat_q[$past(rx_dat_idx_i)] == $past(rx_dat_i);
  endproperty
  a_rxdat: assert property (p_rxdat) else $error("rx body word not stored");

  property p_txdat;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr >= `TXDAT_BASE && h_rel_tx < `DAT_WORDS) |=>
        txdat_q[$past(h_rel_tx[`DAT_IDX_W-1:0])] == $past(host_req_i.wdata);
  endproperty
  a_txdat: assert property (p_txdat) else $error("tx body word not stored");

  property p_user_host;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr >= `USER_BASE && h_rel_u < `USER_WORDS) |=>
        user_q[$past(h_rel_u[`USER_IDX_W-1:0])] == $past(host_req_i.wdata);
  endproperty
  a_user_host: assert property (p_user_host) else $error("host user word not stored");

  property p_user_web;
    @(posedge clk_i) disable iff (rst_i)
      (w_wr && !h_wr && web_req_i.addr >= `USER_BASE && w_rel_u < `USER_WORDS) |=>
        user_q[$past(w_rel_u[`USER_IDX_W-1:0])] == $past(web_req_i.wdata);
  endproperty
  a_user_web: assert property (p_user_web) else $error("web user word not stored");

  property p_rxerr_cap;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && fw_i.rx_done && fw_i.rx_err_v) |=> rxerr_q == $past(fw_i.rx_err);
  endproperty
  a_rxerr_cap: assert property (p_rxerr_cap) else $error("rx error not captured");

  property p_txerr_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !fw_i.tx_err_v) |=> $stable(txerr_q);
  endproperty
  a_txerr_hold: assert property (p_txerr_hold) else $error("tx error changed without event");

  property p_rxlen_hold;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !fw_i.rx_done) |=> $stable(rxlen_q);
  endproperty
  a_rxlen_hold: assert property (p_rxlen_hold) else $error("rx length changed without message");

  property p_cmdf;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr == `CMDF_ADDR) |=> cmdf_q == $past(host_req_i.wdata);
  endproperty
  a_cmdf: assert property (p_cmdf) else $error("command word not stored");

  property p_sync_store;
    @(posedge clk_i) disable iff (rst_i)
      (h_wr && host_req_i.addr == `SYNC_ADDR) |=> sync_q == $past(host_req_i.wdata);
  endproperty
  a_sync_store: assert property (p_sync_store) else $error("sync word not stored");

  property p_rxtag;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && fw_i.rx_done) |=> rxtag_q == $past(fw_i.rx_tag);
  endproperty
  a_rxtag: assert property (p_rxtag) else $error("rx tag not captured");

  property p_web_idle;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !web_req_i.req) |=> !web_rsp_o.valid;
  endproperty
  a_web_idle: assert property (p_web_idle) else $error("web answer without request");
endmodule
`default_nettype wire

/* File: rtl/vdpm_cfg.svh */
// Constants for the virtual register area: word addresses, field offsets, limits.
// Assumes word addressing in 16-bit units; included by the package and the top module.
// Operation
// - Writing the sync word sets the host write indication flag.
// - Reading the sync word clears the host write indication flag.
// - Every unused location reads and resets to zero.
// - Host reaches every register over its own port.
// - Web port reaches only words 0 to 2993 and 5000 to 7999.
// - Words at or above 5000 exist only in the later feature level.
// - Internal side writes received length with the last message byte count.
// - Received error word holds latest reported error code, 32 bits.
// - Transmit error word holds latest failed send error code, 32 bits.
// - Received data area holds latest received message body.
// - Transmit data area holds body the host placed before sending.
// - Transmit tag word holds the 16-bit identifier of latest send.
// - Host and web side both read and write the general user area.
`ifndef VDPM_CFG_SVH
`define VDPM_CFG_SVH
`define ADDR_W        13
`define DATA_W        16
`define SYNC_ADDR     13'h0000
`define CMDF_ADDR     13'h0001
`define RXCMD_ADDR    13'h0002
`define RXERR_ADDR    13'h0004
`define RXLEN_ADDR    13'h0006
`define RXTAG_ADDR    13'h0007
`define TXCMD_ADDR    13'h0008
`define TXERR_ADDR    13'h000a
`define TXLEN_ADDR    13'h000c
`define TXTAG_ADDR    13'h000d
`define HI_OFS        13'h0001
`define RXDAT_BASE    13'h0010
`define TXDAT_BASE    13'h0020
`define DAT_WORDS     16
`define DAT_IDX_W     4
`define USER_BASE     13'h1388
`define USER_WORDS    16
`define USER_IDX_W    4
`define WEB_LO_MAX    13'h0bb1
`define WEB_HI_MIN    13'h1388
`define WEB_HI_MAX    13'h1f3f
`define ZERO16        16'h0000
`define ZERO32        32'h0000_0000
`endif

/* File: rtl/vdpm_pkg.sv */
// Types shared by the register area.
// Assumes vdpm_cfg.svh gives the widths.
`include "vdpm_cfg.svh"
package vdpm_pkg;
  typedef struct packed {
    logic               req;
    logic               we;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic               valid;
    logic [`DATA_W-1:0] rdata;
  } bus_rsp_t;
  typedef struct packed {
    logic        rx_done;
    logic [31:0] rx_cmd;
    logic        rx_err_v;
    logic [31:0] rx_err;
    logic [15:0] rx_len;
    logic [15:0] rx_tag;
    logic        tx_err_v;
    logic [31:0] tx_err;
  } fw_evt_t;
endpackage

/* File: tb/host_model.sv */
// Host master model: one word access at a time on the host port.
// Assumes the register area answers one cycle after it takes a request.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire vdpm_pkg::bus_rsp_t rsp_i,
  input  wire logic               clk_i,
  output vdpm_pkg::bus_req_t      req_o
);
  initial req_o = '0;
  task automatic xfer(input logic we, input logic [12:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic ok);
    rd = 16'h0000;
    ok = 1'b0;
    @(negedge clk_i);
    req_o = '{1'b1, we, a, d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      // A released request never keeps the old address, so a stale decode shows.
      if (n == 0) req_o = '{1'b0, ~we, ~a, ~d};
      if (rsp_i.valid === 1'b1) begin
        ok = (n == 0);
        rd = rsp_i.rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the register area, with a word model of the map.
// Assumes the host model and the design package are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               late  = 1'b1;
  logic               ce    = 1'b1;
  logic               flag;
  logic               fl    = 1'b0;
  logic               rx_we = 1'b0;
  logic [3:0]         rx_ix = 4'h0;
  logic [15:0]        rx_d  = 16'h0000;
  vdpm_pkg::bus_req_t host_req;
  vdpm_pkg::bus_req_t web_req = '0;
  vdpm_pkg::bus_rsp_t host_rsp;
  vdpm_pkg::bus_rsp_t web_rsp;
  vdpm_pkg::fw_evt_t  fw = '0;
  int                 err_total = 0;
  int                 checked = 0;
  logic [15:0]        mem [int];
  int                 web_pts [9] = '{1, 13, 2993, 2994, 4999, 5000, 5015, 7999, 8000};
  always #4 clk_i = ~clk_i;
  host_model host_model_i (.rsp_i(host_rsp), .clk_i(clk_i), .req_o(host_req));
  vdpm_regs vdpm_regs_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .late_level_i(late),
    .host_req_i(host_req), .web_req_i(web_req), .fw_i(fw), .rx_dat_we_i(rx_we),
    .rx_dat_idx_i(rx_ix), .rx_dat_i(rx_d), .host_rsp_o(host_rsp), .web_rsp_o(web_rsp),
    .host_write_indication_flag_o(flag));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic bit vis(bit web, int a);
    if (a >= 5000 && !late) return 0;
    return !web || a <= 2993 || (a >= 5000 && a <= 7999);
  endfunction
  // Only the sync word and the user area take writes from the web port.
  function automatic bit wr_ok(bit web, int a);
    if (web) return a inside {0, [5000:5015]};
    return a inside {0, 1, 8, 9, 12, 13, [32:47], [5000:5015]};
  endfunction
  task automatic web_xfer(input logic we, input logic [12:0] a, input logic [15:0] d,
                          output logic [15:0] rd, output logic ok);
    rd = 16'h0000;
    ok = 1'b0;
    @(negedge clk_i);
    web_req = '{1'b1, we, a, d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_i);
      if (n == 0) web_req = '{1'b0, ~we, ~a, ~d};
      if (web_rsp.valid === 1'b1) begin
        ok = (n == 0);
        rd = web_rsp.rdata;
      end
    end
  endtask
  // word access compared with the model
  task automatic acc(input bit web, input bit we, input int a, input logic [15:0] d);
    logic [15:0] rd;
    logic [15:0] exp;
    logic        ok;
    exp = (vis(web, a) && mem.exists(a)) ? mem[a] : 16'h0000;
    if (web) web_xfer(we, a[12:0], d, rd, ok);
    else host_model_i.xfer(we, a[12:0], d, rd, ok);
    if (a == 0) fl = we;
    if (we && vis(web, a) && wr_ok(web, a)) mem[a] = d;
    chk({15'h0, ok}, 16'h0001);
    chk(rd, we ? 16'h0000 : exp);
    chk({15'h0, flag}, {15'h0, fl});
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    mem.delete();
    fl = 1'b0;
  endtask
  task automatic fw_evt(input bit ev, input bit tv);
    logic [31:0] c;
    logic [31:0] e;
    logic [31:0] t;
    logic [31:0] lt;
    c = $urandom;
    e = $urandom;
    t = $urandom;
    lt = $urandom;
    @(negedge clk_i);
    fw = '{1'b1, c, ev, e, lt[15:0], lt[31:16], tv, t};
    if (ce) {mem[3], mem[2], mem[7], mem[6]} = {c, lt};
    if (ce && ev) {mem[5], mem[4]} = e;
    if (ce && tv) {mem[11], mem[10]} = t;
    @(negedge clk_i);
    fw = '0;
  endtask
  initial begin
    #800000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hcbbf7b0e));
    do_reset();
    for (int a = 1; a < 64; a++) acc(0, 0, a, 16'h0000);
    acc(0, 1, 0, 16'h5a5a);
    acc(0, 0, 0, 16'h0000);
    acc(1, 1, 0, 16'h1234);
    acc(1, 0, 0, 16'h0000);
    $display("test sync done");
    fw_evt(1, 1);
    fw_evt(0, 0);
    // A firmware event under a low clock enable must leave every word as it was.
    ce = 1'b0;
    fw_evt(1, 1);
    ce = 1'b1;
    for (int a = 2; a < 14; a++) acc(0, 0, a, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      {rx_we, rx_ix, rx_d} = {1'b1, i[3:0], 16'($urandom)};
      mem[16 + i] = rx_d;
      @(negedge clk_i);
      rx_we = 1'b0;
    end
    for (int a = 1; a < 48; a++) begin
      acc(0, 1, a, 16'($urandom));
      acc(0, 0, a, 16'h0000);
    end
    $display("test firmware and host done");
    foreach (web_pts[i]) begin
      acc(1, 1, web_pts[i], 16'($urandom));
      acc(1, 0, web_pts[i], 16'h0000);
      acc(0, 0, web_pts[i], 16'h0000);
    end
    @(negedge clk_i);
    late = 1'b0;
    acc(0, 1, 5001, 16'hbeef);
    acc(0, 0, 5000, 16'h0000);
    acc(1, 0, 5015, 16'h0000);
    @(negedge clk_i);
    late = 1'b1;
    acc(0, 0, 5001, 16'h0000);
    $display("test web and level done");
    for (int n = 0; n < 300; n++) begin
      acc(1'($urandom % 2), 1'($urandom % 2),
          ($urandom % 2) ? $urandom % 64 : 4990 + $urandom % 32, 16'($urandom));
    end
    do_reset();
    for (int a = 0; a < 48; a += 3) acc(1, 0, a, 16'h0000);
    acc(0, 0, 5000, 16'h0000);
    $display("test random and reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
